// ===== logic/rxb_cfg.svh
// Offsets, field positions, reset values and sizes of the receive buffer block.
`ifndef RXB_CFG_SVH
`define RXB_CFG_SVH
`define RXB_DEPTH        96
`define RXB_HI_MARK      7'h58
`define RXB_LO_MARK      7'h40
`define RXB_BITS_LONG    4'hB
`define RXB_BITS_SHORT   4'hA
`define RXB_A_CTRL       8'h00
`define RXB_A_STATUS     8'h04
`define RXB_A_RXDATA     8'h08
`define RXB_A_OVFBITS    8'h0C
`define RXB_A_STG_TMO    8'h10
`define RXB_A_STG_CUR    8'h14
`define RXB_A_STG_VID    8'h18
`define RXB_A_STG_PID    8'h1C
`define RXB_A_STR_CHAR   8'h20
`define RXB_A_PW_LO      8'h24
`define RXB_A_PW_HI      8'h28
`define RXB_A_NPW_LO     8'h2C
`define RXB_A_NPW_HI     8'h30
`define RXB_A_CMD        8'h34
`define RXB_A_CFG_TMO    8'h38
`define RXB_A_CFG_CUR    8'h3C
`define RXB_A_CFG_IDS    8'h40
`define RXB_CMD_READ     0
`define RXB_CMD_APPLY    1
`define RXB_CMD_NEWPW    2
`define RXB_ST_OVERFLOW  8
`define RXB_ST_DROP      9
`define RXB_TMO_MIN      7'h01
`define RXB_TMO_MAX      7'h63
`define RXB_TMO_RST      7'h0A
`define RXB_CUR_MIN      9'h014
`define RXB_CUR_MAX      9'h1F4
`define RXB_CUR_RST      9'h064
`define RXB_PW_RST       64'hFFFF_FFFF_FFFF_FFFF
`endif

// ===== logic/rxb_pkg.sv
// Types shared by the receive buffer block.
`default_nettype none
package rxb_pkg;
  typedef enum logic [1:0] {
    RXB_FLOW_NONE = 2'b00,
    RXB_FLOW_HW   = 2'b01,
    RXB_FLOW_SW   = 2'b10
  } rxb_flow_type;
  typedef struct packed {
    logic [6:0]  timeout_ms;
    logic [8:0]  max_current;
    logic        self_powered;
    logic [15:0] vid;
    logic [15:0] pid;
  } rxb_cfg_type;
endpackage
`default_nettype wire

// ===== logic/rxb_core.sv
// Serial receive buffer with flow control and guarded configuration store.
// Functional notes
// RULE1: 96-byte receive buffer held until host reads.
// RULE2: No flow control: new bytes overwrite oldest.
// RULE3: Flow control on: buffer never overflows.
// RULE4: Overflow time is bits-per-byte times 96.
// RULE5: Receive timeout accepted only from 1 to 99.
// RULE6: Current even 20..500; zero means self powered.
// RULE7: Settings readable only after password match.
// RULE8: Apply change only if all fields valid.
// RULE9: Identifiers accept only hex digits 0-9, A-F.
// RULE10: Strings accept any printable ASCII character.
// RULE11: New password replaces stored one on change.
// RULE12: Throttle sender by RTS or XOFF/XON near full.
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.
`include "rxb_cfg.svh"
`default_nettype none
module rxb_core #(
  parameter logic [15:0] VID_RST = 16'h1234,  // Arbitrary value.
  parameter logic [15:0] PID_RST = 16'h0001   // Arbitrary value.
) (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               nrst_i,
  // AHB-Lite slave
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic      [31:0]        hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  // Serial receive side
  input  wire logic [7:0]         rx_byte_i,
  input  wire logic               rx_valid_i,
  output logic                    rts_n_o,
  output logic                    xoff_o,
  output logic                    xon_o,
  // Active configuration
  output rxb_pkg::rxb_cfg_type    cfg_o
);

  function automatic logic is_hex(input logic [7:0] c);
    is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    hex_val = (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
  endfunction

  function automatic logic [6:0] ptr_inc(input logic [6:0] p);
    ptr_inc = (p == 7'(`RXB_DEPTH - 1)) ? 7'h00 : 7'(p + 7'h01);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: writes take effect in the data phase, reads add one wait state.
  logic                  dp_wr;
  logic                  dp_rd;
  logic [7:0]            dp_addr;
  logic [7:0]            mem [`RXB_DEPTH];
  logic [6:0]            wr_ptr;
  logic [6:0]            rd_ptr;
  logic [6:0]            count;
  logic                  overflow;
  logic                  dropped;
  logic                  throttle;
  rxb_pkg::rxb_flow_type flow;
  logic                  long_char;
  logic [6:0]            stg_tmo;
  logic [8:0]            stg_cur;
  logic [31:0]           stg_vid;
  logic [31:0]           stg_pid;
  logic                  str_bad;
  logic [63:0]           pw_entry;
  logic [63:0]           npw_entry;
  logic [63:0]           pw;
  logic                  unlocked;
  logic                  apply_ok;
  logic                  apply_fail;
  rxb_pkg::rxb_cfg_type  cfg;

  wire        acc      = hsel_i & htrans_i[1] & hready_i;
  wire        wr_en    = dp_wr;
  wire [31:0] wd       = hwdata_i;
  wire        wr_ctrl  = wr_en & (dp_addr == `RXB_A_CTRL);
  wire        wr_stat  = wr_en & (dp_addr == `RXB_A_STATUS);
  wire        wr_cmd   = wr_en & (dp_addr == `RXB_A_CMD);
  wire        wr_str   = wr_en & (dp_addr == `RXB_A_STR_CHAR);
  wire        cmd_read = wr_cmd & wd[`RXB_CMD_READ];
  wire        cmd_app  = wr_cmd & wd[`RXB_CMD_APPLY];
  wire        pop      = dp_rd & (dp_addr == `RXB_A_RXDATA) & (count != 7'h00);

  assign hreadyout_o = ~dp_rd;
  assign hresp_o     = 1'b0;
  assign cfg_o       = cfg;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr <= acc & hwrite_i;
      dp_rd <= acc & ~hwrite_i;
      if (acc) begin
        dp_addr <= {haddr_i[7:2], 2'b00};
      end
    end
  end

  // Configuration reads show zero until the password has been presented.
  wire [31:0] cfg_tmo_rd = unlocked ? {25'h0, cfg.timeout_ms} : 32'h0; // [RULE7]
  wire [31:0] cfg_cur_rd = unlocked ? {15'h0, cfg.self_powered, 7'h0, cfg.max_current} : 32'h0;
  wire [31:0] cfg_ids_rd = unlocked ? {cfg.vid, cfg.pid} : 32'h0;
  wire [3:0]  bits_pb    = long_char ? `RXB_BITS_LONG : `RXB_BITS_SHORT;
  wire [31:0] ovf_bits   = 32'(bits_pb) * 32'(`RXB_DEPTH); // [RULE4]
  wire [31:0] status_rd  = {19'h0, apply_fail, apply_ok, unlocked, dropped, overflow,
                            1'b0, count};
  wire [31:0] rdata =
    (dp_addr == `RXB_A_CTRL)    ? {28'h0, long_char, 1'b0, flow} :
    (dp_addr == `RXB_A_STATUS)  ? status_rd :
    (dp_addr == `RXB_A_RXDATA)  ? {23'h0, pop, pop ? mem[rd_ptr] : 8'h00} :
    (dp_addr == `RXB_A_OVFBITS) ? ovf_bits :
    (dp_addr == `RXB_A_CFG_TMO) ? cfg_tmo_rd :
    (dp_addr == `RXB_A_CFG_CUR) ? cfg_cur_rd :
    (dp_addr == `RXB_A_CFG_IDS) ? cfg_ids_rd : 32'h0;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrdata_o <= 32'h0;
    end else if (dp_rd) begin
      hrdata_o <= rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive buffer. Without flow control a full buffer drops its oldest byte.
  wire mode_none = (flow == rxb_pkg::RXB_FLOW_NONE);
  wire full      = (count == 7'(`RXB_DEPTH));
  wire do_wr     = rx_valid_i & (~full | pop | mode_none); // [RULE1] [RULE3]
  wire overwrite = rx_valid_i & full & ~pop & mode_none;   // [RULE2]
  wire do_rd     = pop | overwrite;
  wire [6:0] next_count = 7'(count + 7'(do_wr) - 7'(do_rd));

  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= rx_byte_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      count  <= 7'h00;
    end else begin
      wr_ptr <= do_wr ? ptr_inc(wr_ptr) : wr_ptr;
      rd_ptr <= do_rd ? ptr_inc(rd_ptr) : rd_ptr;
      count  <= next_count;
    end
  end

  // Sticky error flags; a new event wins over a write-one-to-clear.
  wire drop_ev = rx_valid_i & full & ~pop & ~mode_none;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overflow <= 1'b0;
      dropped  <= 1'b0;
    end else begin
      overflow <= overwrite | (overflow & ~(wr_stat & wd[`RXB_ST_OVERFLOW]));
      dropped  <= drop_ev | (dropped & ~(wr_stat & wd[`RXB_ST_DROP]));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flow control. The high mark leaves eight bytes of slack for a sender that
  // is slow to react to RTS or XOFF.
  wire next_throttle = ~mode_none & ((count >= `RXB_HI_MARK) |
                                     (throttle & (count > `RXB_LO_MARK)));

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      throttle <= 1'b0;
      rts_n_o  <= 1'b0;
      xoff_o   <= 1'b0;
      xon_o    <= 1'b0;
    end else begin
      throttle <= next_throttle;
      rts_n_o  <= next_throttle & (flow == rxb_pkg::RXB_FLOW_HW);                // [RULE12]
      xoff_o   <= next_throttle & ~throttle & (flow == rxb_pkg::RXB_FLOW_SW);   // [RULE12]
      xon_o    <= ~next_throttle & throttle & (flow == rxb_pkg::RXB_FLOW_SW);   // [RULE12]
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flow      <= rxb_pkg::RXB_FLOW_NONE;
      long_char <= 1'b0;
    end else if (wr_ctrl) begin
      flow      <= rxb_pkg::rxb_flow_type'(wd[1:0]);
      long_char <= wd[3];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Staging of a configuration change and its checks.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stg_tmo   <= 7'h00;
      stg_cur   <= 9'h000;
      stg_vid   <= 32'h0;
      stg_pid   <= 32'h0;
      pw_entry  <= 64'h0;
      npw_entry <= 64'h0;
    end else if (wr_en) begin
      if (dp_addr == `RXB_A_STG_TMO) stg_tmo <= wd[6:0];
      if (dp_addr == `RXB_A_STG_CUR) stg_cur <= wd[8:0];
      if (dp_addr == `RXB_A_STG_VID) stg_vid <= wd;
      if (dp_addr == `RXB_A_STG_PID) stg_pid <= wd;
      if (dp_addr == `RXB_A_PW_LO)   pw_entry[31:0]   <= wd;
      if (dp_addr == `RXB_A_PW_HI)   pw_entry[63:32]  <= wd;
      if (dp_addr == `RXB_A_NPW_LO)  npw_entry[31:0]  <= wd;
      if (dp_addr == `RXB_A_NPW_HI)  npw_entry[63:32] <= wd;
    end
  end

  // A string character outside the printable range spoils the next apply.
  wire chr_bad = (wd[7:0] < 8'h20) | (wd[7:0] > 8'h7E); // [RULE10]

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      str_bad <= 1'b0;
    end else begin
      str_bad <= (wr_str & chr_bad) | (str_bad & ~cmd_app);
    end
  end

  wire tmo_ok  = (stg_tmo >= `RXB_TMO_MIN) & (stg_tmo <= `RXB_TMO_MAX);            // [RULE5]
  wire cur_ok  = (stg_cur == 9'h000) |
                 (~stg_cur[0] & (stg_cur >= `RXB_CUR_MIN) & (stg_cur <= `RXB_CUR_MAX)); // [RULE6]
  wire ids_ok  = is_hex(stg_vid[31:24]) & is_hex(stg_vid[23:16]) &
                 is_hex(stg_vid[15:8])  & is_hex(stg_vid[7:0])   &
                 is_hex(stg_pid[31:24]) & is_hex(stg_pid[23:16]) &
                 is_hex(stg_pid[15:8])  & is_hex(stg_pid[7:0]);                    // [RULE9]
  wire all_ok  = tmo_ok & cur_ok & ids_ok & ~str_bad;                             // [RULE8]
  wire pw_ok   = (pw_entry == pw);                                                // [RULE7]
  wire commit  = cmd_app & pw_ok & all_ok;
  wire new_pw  = commit & wd[`RXB_CMD_NEWPW];
  wire [15:0] vid_bin = {hex_val(stg_vid[31:24]), hex_val(stg_vid[23:16]),
                         hex_val(stg_vid[15:8]),  hex_val(stg_vid[7:0])};
  wire [15:0] pid_bin = {hex_val(stg_pid[31:24]), hex_val(stg_pid[23:16]),
                         hex_val(stg_pid[15:8]),  hex_val(stg_pid[7:0])};

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg <= '{timeout_ms: `RXB_TMO_RST, max_current: `RXB_CUR_RST, self_powered: 1'b0,
               vid: VID_RST, pid: PID_RST};
    end else if (commit) begin
      cfg <= '{timeout_ms: stg_tmo, max_current: stg_cur,
               self_powered: (stg_cur == 9'h000), vid: vid_bin, pid: pid_bin}; // [RULE6] [RULE8]
    end
  end

  // A password change locks the settings until the new one is presented.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pw         <= `RXB_PW_RST;
      unlocked   <= 1'b0;
      apply_ok   <= 1'b0;
      apply_fail <= 1'b0;
    end else begin
      pw       <= new_pw ? npw_entry : pw;                                       // [RULE11]
      unlocked <= ~new_pw & (cmd_read ? pw_ok : unlocked);                       // [RULE7] [RULE11]
      if (cmd_app) begin
        apply_ok   <= commit;
        apply_fail <= ~commit;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  buf_cap_a: assert property (count <= 7'(`RXB_DEPTH))  // [RULE1]
    else $error("buffer count above capacity");
  oldest_drop_a: assert property (overwrite |=>  // [RULE2]
                                  count == 7'(`RXB_DEPTH) && overflow &&
                                  rd_ptr == ptr_inc($past(rd_ptr)))
    else $error("overwrite did not discard oldest byte");
  no_overflow_a: assert property (!mode_none && rx_valid_i && full && !pop |=>  // [RULE3]
                                  count == 7'(`RXB_DEPTH) && $stable(rd_ptr))
    else $error("flow controlled buffer lost data");
  ovf_time_a: assert property (long_char |-> ovf_bits == 32'h0000_0420)  // [RULE4]
    else $error("overflow time wrong");
  tmo_range_a: assert property (cfg.timeout_ms >= `RXB_TMO_MIN &&  // [RULE5]
                                cfg.timeout_ms <= `RXB_TMO_MAX)
    else $error("timeout outside range");
  cur_value_a: assert property (cfg.self_powered ? cfg.max_current == 9'h000 :  // [RULE6]
                                (!cfg.max_current[0] && cfg.max_current >= `RXB_CUR_MIN))
    else $error("current setting invalid");
  unlock_gate_a: assert property ($rose(unlocked) |-> $past(cmd_read && pw_ok))  // [RULE7]
    else $error("unlocked without password");
  cfg_guard_a: assert property ($changed(cfg) |-> $past(cmd_app && all_ok && pw_ok))  // [RULE8]
    else $error("config changed without valid fields");
  pw_replace_a: assert property (new_pw |=> pw == $past(npw_entry) && !unlocked)  // [RULE11]
    else $error("password not replaced");
  rts_stop_a: assert property (flow == rxb_pkg::RXB_FLOW_HW && count >= `RXB_HI_MARK  // [RULE12]
                               ##1 flow == rxb_pkg::RXB_FLOW_HW |-> rts_n_o)
    else $error("rts not deasserted near full");

endmodule
`default_nettype wire

// ===== verif/rxb_peer.sv
// Serial sender model that feeds the receive buffer and obeys its throttle outputs.
`default_nettype none
module rxb_peer (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // Bench control
  input  wire logic        go_i,
  input  wire logic [3:0]  gap_i,
  input  wire logic [7:0]  base_i,
  // Throttle from the buffer
  input  wire logic        rts_n_i,
  input  wire logic        xoff_i,
  input  wire logic        xon_i,
  // Bytes towards the buffer, and sender status for the bench
  output logic      [7:0]  rx_byte_o,
  output logic             rx_valid_o,
  output logic             paused_o,
  output logic      [15:0] sent_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_byte_o  <= 8'h00;
      rx_valid_o <= 1'b0;
      paused_o   <= 1'b0;
      sent_o     <= 16'h0000;
      wait_q     <= 4'h0;
    end else begin
      // A stale byte would hide a sampling slip, so the idle data toggles.
      rx_byte_o  <= ~rx_byte_o;
      rx_valid_o <= 1'b0;
      if (xoff_i) begin
        paused_o <= 1'b1;
      end else if (xon_i) begin
        paused_o <= 1'b0;
      end
      if (wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (go_i && !paused_o && !xoff_i && !rts_n_i) begin
        rx_valid_o <= 1'b1;
        rx_byte_o  <= base_i + sent_o[7:0];
        sent_o     <= sent_o + 16'h0001;
        wait_q     <= gap_i;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_uart_rx_buffer_flow_config.sv
// Self-checking bench of the receive buffer: overflow, flow control and settings store.
`include "rxb_cfg.svh"
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin num_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module test_uart_rx_buffer_flow_config;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clk = 1'b0;
  logic                 nrst = 1'b0;
  logic [1:0]           htrans = 2'b00;
  logic [31:0]          haddr = 32'h0, hwdata = 32'h0, hrdata, st;
  logic                 hwrite = 1'b0, hready, hresp, rx_valid, rts_n, xoff, xon;
  logic                 go = 1'b0, paused;
  logic [3:0]           gap = 4'h1;
  logic [7:0]           base = 8'h00, rx_byte, b0, t8, c8;
  logic [15:0]          sent, s0;
  logic [31:0]          v, p;
  logic [63:0]          pw = `RXB_PW_RST, npw, opw;
  rxb_pkg::rxb_cfg_type cfg, ecfg = {7'h0A, 9'h064, 1'b0, 16'h1234, 16'h0001};
  int                   num_errors = 0, total_checks = 0;
  rxb_core rxb_core_i (.sys_clk_i(clk), .nrst_i(nrst), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .rts_n_o(rts_n), .xoff_o(xoff),
    .xon_o(xon), .cfg_o(cfg));
  rxb_peer rxb_peer_i (.sys_clk_i(clk), .nrst_i(nrst), .go_i(go), .gap_i(gap), .base_i(base),
    .rts_n_i(rts_n), .xoff_i(xoff), .xon_i(xon), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .paused_o(paused), .sent_o(sent));
  initial begin
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Called just after a rising edge; every wait is bounded.
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 50);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
    if (n >= 50) begin num_errors++; final_report(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask
  task automatic send(input int k, input logic must);
    int n;
    logic [7:0] r;
    r = 8'($urandom);
    b0 = r + sent[7:0];
    s0 = sent;
    base <= r;
    gap <= 4'($urandom_range(3, 1));
    go <= 1'b1;
    n = 0;
    while (sent != s0 + 16'(k) && n < 1000) begin @(posedge clk); n++; end
    go <= 1'b0;
    if (must && n >= 1000) begin num_errors++; final_report(); end
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [31:0] hexstr(input logic [15:0] x);
    for (int k = 0; k < 4; k++)
      hexstr[8*k +: 8] = 8'(x[4*k +: 4]) + ((x[4*k +: 4] < 4'hA) ? 8'h30 : 8'h37);
  endfunction
  // Bit 16 reports that all four characters are upper-case hexadecimal digits.
  function automatic logic [16:0] hexval(input logic [31:0] s);
    logic [7:0] c;
    hexval = 17'h10000;
    for (int k = 0; k < 4; k++) begin
      c = s[8*k +: 8];
      if (c >= 8'h30 && c <= 8'h39) hexval[4*k +: 4] = 4'(c - 8'h30);
      else if (c >= 8'h41 && c <= 8'h46) hexval[4*k +: 4] = 4'(c - 8'h37);
      else hexval[16] = 1'b0;
    end
  endfunction
  task automatic apply(input logic [6:0] t, input logic [8:0] c, input logic [7:0] ch,
                       input logic np);
    logic [16:0] hv, hp;
    logic ok;
    hv = hexval(v);
    hp = hexval(p);
    ok = t >= 7'h01 && t <= 7'h63 && (c == 9'h000 || (!c[0] && c >= 9'h014 && c <= 9'h1F4))
         && hv[16] && hp[16] && ch >= 8'h20 && ch <= 8'h7E;
    wr(`RXB_A_STG_TMO, {25'h0, t});
    wr(`RXB_A_STG_CUR, {23'h0, c});
    wr(`RXB_A_STG_VID, v);
    wr(`RXB_A_STG_PID, p);
    wr(`RXB_A_STR_CHAR, {24'h0, ch});
    wr(`RXB_A_PW_LO, pw[31:0]);
    wr(`RXB_A_PW_HI, pw[63:32]);
    wr(`RXB_A_CMD, {29'h0, np, 2'b10});
    if (ok) ecfg = {t, c, c == 9'h000, hv[15:0], hp[15:0]};
    if (ok && np) pw = npw;
    rd(`RXB_A_STATUS, st);
    `CHK("apply_flags", ok ? 2'b01 : 2'b10, st[12:11])
    `CHK("cfg", ecfg, cfg)
  endtask
  task automatic unlock(input logic [63:0] k, input logic ex);
    wr(`RXB_A_PW_LO, k[31:0]);
    wr(`RXB_A_PW_HI, k[63:32]);
    wr(`RXB_A_CMD, 32'h1);
    rd(`RXB_A_STATUS, st);
    `CHK("unlocked", ex, st[10])
    rd(`RXB_A_CFG_IDS, st);
    `CHK("cfg_ids", ex ? {ecfg.vid, ecfg.pid} : 32'h0, st)
    rd(`RXB_A_CFG_CUR, st);
    `CHK("cfg_cur", ex ? {15'h0, ecfg.self_powered, 7'h0, ecfg.max_current} : 32'h0, st)
    rd(`RXB_A_CFG_TMO, st);
    `CHK("cfg_tmo", ex ? {25'h0, ecfg.timeout_ms} : 32'h0, st)
  endtask
  task automatic pop_check(input int k);
    for (int j = 0; j < k; j++) begin
      rd(`RXB_A_RXDATA, st);
      `CHK("rx_byte", {23'h0, 1'b1, 8'(b0 + j)}, st)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h9e4a1872));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    `CHK("cfg_reset", ecfg, cfg)
    rd(`RXB_A_OVFBITS, st);
    `CHK("ovf_bits_short", 32'h3C0, st)
    wr(`RXB_A_CTRL, 32'h8);
    rd(`RXB_A_OVFBITS, st);
    `CHK("ovf_bits_long", 32'h420, st)
    wr(`RXB_A_CTRL, 32'h0);
    send(100, 1'b1);
    rd(`RXB_A_STATUS, st);
    `CHK("full_count", 7'h60, st[6:0])
    `CHK("overflow", 1'b1, st[8])
    b0 = b0 + 8'h04;
    pop_check(96);
    rd(`RXB_A_RXDATA, st);
    `CHK("empty_read", 32'h0, st)
    wr(`RXB_A_STATUS, 32'h100);
    rd(`RXB_A_STATUS, st);
    `CHK("overflow_clear", 1'b0, st[8])
    $display("test overflow without flow control done");
    for (int m = 1; m < 3; m++) begin
      wr(`RXB_A_CTRL, 32'(m));
      send(200, 1'b0);
      `CHK("throttled", 1'b1, (m == 1) ? rts_n : paused)
      rd(`RXB_A_STATUS, st);
      `CHK("count_held", 1'b1, st[6:0] >= 7'h58 && st[6:0] <= 7'h60)
      `CHK("no_drop", 1'b0, st[9])
      pop_check(30);
      repeat (4) @(posedge clk);
      `CHK("released", 1'b0, (m == 1) ? rts_n : paused)
      rd(`RXB_A_STATUS, st);
      repeat (st[6:0]) rd(`RXB_A_RXDATA, st);
      $display("test flow mode %0d done", m);
    end
    // Mode 3 holds back no pin, so a sender that keeps going fills the buffer and the
    // newest bytes must be dropped while the oldest stay.
    wr(`RXB_A_CTRL, 32'h3);
    send(100, 1'b1);
    rd(`RXB_A_STATUS, st);
    `CHK("drop_count", 7'h60, st[6:0])
    `CHK("dropped", 2'b10, st[9:8])
    `CHK("no_pin_throttle", 2'b00, {rts_n, paused})
    pop_check(96);
    wr(`RXB_A_STATUS, 32'h200);
    rd(`RXB_A_STATUS, st);
    `CHK("dropped_clear", 1'b0, st[9])
    $display("test flow mode 3 done");
    unlock(~pw, 1'b0);
    unlock(pw, 1'b1);
    for (int i = 0; i < 14; i++) begin
      t8 = 8'($urandom_range(99, 1));
      c8 = 8'($urandom_range(250, 10));
      v = hexstr(16'($urandom));
      p = hexstr(16'($urandom));
      case (i)
        1: t8 = 8'h00;
        2: t8 = 8'h64;
        3: t8 = 8'h63;
        4: c8 = 8'h00;
        9: v[7:0] = 8'h61;
        10: p[31:24] = 8'h47;
        default: ;
      endcase
      apply(t8[6:0], (i == 5) ? 9'h015 : (i == 6) ? 9'h1F6 : (i == 7) ? 9'h1F4 :
            (i == 8) ? 9'h012 : {c8, 1'b0}, (i == 11) ? 8'h1F : (i == 12) ? 8'h7F :
            (i == 13) ? 8'h20 : 8'($urandom_range(126, 32)), 1'b0);
    end
    $display("test settings checks done");
    opw = pw;
    npw = {$urandom, $urandom};
    wr(`RXB_A_NPW_LO, npw[31:0]);
    wr(`RXB_A_NPW_HI, npw[63:32]);
    v = hexstr(16'hC0DE);
    p = hexstr(16'h0042);
    apply(7'h05, 9'h0C8, 8'h41, 1'b1);
    unlock(opw, 1'b0);
    unlock(pw, 1'b1);
    rd(8'h80, st);
    `CHK("unmapped", 32'h0, st)
    $display("test password change done");
    final_report();
  end
endmodule
`default_nettype wire
